//--- ltr_recognizer.v
// Logic trigger recognizer top: APB registers, functions, sequencer, IRQ
`timescale 1ns/1ns
`include "ltr_consts.vh"

//////////////////////////////////////////////////////////////////////
// Register map, one 32-bit word per register
// 0x00 control: select B, sequential, qualify enable, qualify on fall, disarm
// 0x04 and 0x08 function A products, 0x0C and 0x10 function B products
// Product word: care mask, wanted levels, edge channel, edge mode, enable
// 0x14 filter hold in cycles, clamped to the 300 ns limit
// 0x18 status: armed, synced channels, hit A, hit B
// 0x1C event flags, write one to clear; 0x20 event mask
// Unmapped reads return zero and unmapped writes are dropped
//////////////////////////////////////////////////////////////////////

module ltr_recognizer (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Thresholded channels and qualify clock, asynchronous
   input wire [3:0] chan_level,
   input wire external_qualify_clock,
   // External reset from delay unit, asynchronous
   input wire ext_seq_reset,
   // Trigger outputs
   output reg trigger_out,
   output reg seq_gate,
   output reg trigger_monitor_trace,
   output wire irq
);
   localparam ST_IDLE = 1'b0;
   localparam ST_ARMED = 1'b1;
   // Longest filter hold in clock cycles
   localparam [31:0] FILT_MAX_W = `LTR_FILTER_MAX_CYC;
   localparam [4:0] FILT_MAX = FILT_MAX_W[4:0];

   //////////////////////////////////////////////////////////////////////
   // Registers
   reg [4:0] ctrl_ff;
   reg [12:0] fa0_ff;
   reg [12:0] fa1_ff;
   reg [12:0] fb0_ff;
   reg [12:0] fb1_ff;
   reg [4:0] filt_ff;
   reg [2:0] irq_stat_ff;
   reg [2:0] irq_mask_ff;
   reg [2:0] nxt_irq_stat;
   reg state_ff;
   reg nxt_state;

   // Synchronisers
   reg [3:0] ch_s1_ff;
   reg [3:0] ch_s2_ff;
   reg [3:0] ch_prev_ff;
   reg qc_s1_ff;
   reg qc_s2_ff;
   reg qc_prev_ff;
   reg rs_s1_ff;
   reg rs_s2_ff;
   reg rs_prev_ff;

   wire wr_en;
   wire rd_en;
   wire hit_a;
   wire hit_b;
   wire qual;
   wire ext_rst_pulse;
   wire sw_rst_pulse;
   reg hit_a_d_ff;
   reg hit_b_d_ff;
   wire rise_a;
   wire rise_b;
   reg ev_arm;
   reg ev_trig;

   //////////////////////////////////////////////////////////////////////
   // APB access, zero wait states
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   always @(posedge clock) begin
      if (sys_rst) begin
         ctrl_ff <= `LTR_CTRL_RST;
         fa0_ff <= `LTR_PT_RST;
         fa1_ff <= `LTR_PT_RST;
         fb0_ff <= `LTR_PT_RST;
         fb1_ff <= `LTR_PT_RST;
         filt_ff <= `LTR_FILTER_RST;
         irq_mask_ff <= `LTR_MASK_RST;
      end else begin
         // Software reset bit is self-clearing
         ctrl_ff[`LTR_CTRL_SW_RESET] <= 1'b0;
         if (wr_en) begin
            if (paddr == `LTR_OFS_CTRL) begin
               ctrl_ff <= pwdata[4:0];
            end else if (paddr == `LTR_OFS_FUNC_A0) begin
               fa0_ff <= pwdata[12:0];
            end else if (paddr == `LTR_OFS_FUNC_A1) begin
               fa1_ff <= pwdata[12:0];
            end else if (paddr == `LTR_OFS_FUNC_B0) begin
               fb0_ff <= pwdata[12:0];
            end else if (paddr == `LTR_OFS_FUNC_B1) begin
               fb1_ff <= pwdata[12:0];
            end else if (paddr == `LTR_OFS_FILTER) begin
               // Whole word compared so large values clamp instead of wrapping
               filt_ff <= (pwdata > FILT_MAX_W) ? FILT_MAX : pwdata[4:0];
            end else if (paddr == `LTR_OFS_IRQ_MASK) begin
               irq_mask_ff <= pwdata[2:0];
            end
         end
      end
   end

   // Read data captured in setup, stable through access
   always @(posedge clock) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         if (paddr == `LTR_OFS_CTRL) begin
            prdata <= {27'h0000000, ctrl_ff};
         end else if (paddr == `LTR_OFS_FUNC_A0) begin
            prdata <= {19'h00000, fa0_ff};
         end else if (paddr == `LTR_OFS_FUNC_A1) begin
            prdata <= {19'h00000, fa1_ff};
         end else if (paddr == `LTR_OFS_FUNC_B0) begin
            prdata <= {19'h00000, fb0_ff};
         end else if (paddr == `LTR_OFS_FUNC_B1) begin
            prdata <= {19'h00000, fb1_ff};
         end else if (paddr == `LTR_OFS_FILTER) begin
            prdata <= {27'h0000000, filt_ff};
         end else if (paddr == `LTR_OFS_STATUS) begin
            prdata <= {25'h0000000, hit_b, hit_a, ch_s2_ff, state_ff};
         end else if (paddr == `LTR_OFS_IRQ_STAT) begin
            prdata <= {29'h00000000, irq_stat_ff};
         end else if (paddr == `LTR_OFS_IRQ_MASK) begin
            prdata <= {29'h00000000, irq_mask_ff};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Input synchronisers and previous samples
   always @(posedge clock) begin
      if (sys_rst) begin
         ch_s1_ff <= 4'h0;
         ch_s2_ff <= 4'h0;
         ch_prev_ff <= 4'h0;
         qc_s1_ff <= 1'b0;
         qc_s2_ff <= 1'b0;
         qc_prev_ff <= 1'b0;
         rs_s1_ff <= 1'b0;
         rs_s2_ff <= 1'b0;
         rs_prev_ff <= 1'b0;
      end else begin
         ch_s1_ff <= chan_level;
         ch_s2_ff <= ch_s1_ff;
         ch_prev_ff <= ch_s2_ff;
         qc_s1_ff <= external_qualify_clock;
         qc_s2_ff <= qc_s1_ff;
         qc_prev_ff <= qc_s2_ff;
         rs_s1_ff <= ext_seq_reset;
         rs_s2_ff <= rs_s1_ff;
         rs_prev_ff <= rs_s2_ff;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Trigger functions A and B
   ltr_function u_func_a (
      .clock(clock),
      .sys_rst(sys_rst),
      .term0_cfg(fa0_ff),
      .term1_cfg(fa1_ff),
      .filter_cyc(filt_ff),
      .lvl_now(ch_s2_ff),
      .lvl_prev(ch_prev_ff),
      .func_hit(hit_a)
   );

   ltr_function u_func_b (
      .clock(clock),
      .sys_rst(sys_rst),
      .term0_cfg(fb0_ff),
      .term1_cfg(fb1_ff),
      .filter_cyc(filt_ff),
      .lvl_now(ch_s2_ff),
      .lvl_prev(ch_prev_ff),
      .func_hit(hit_b)
   );

   // Qualify clock edge enables evaluation
   assign qual = !ctrl_ff[`LTR_CTRL_QCLK_EN] ||
      (ctrl_ff[`LTR_CTRL_QCLK_FALL] ? (qc_prev_ff && !qc_s2_ff) : (!qc_prev_ff && qc_s2_ff));

   // Recognition counts once per true interval, or once per qualify edge
   assign rise_a = qual && hit_a && (ctrl_ff[`LTR_CTRL_QCLK_EN] || !hit_a_d_ff);
   assign rise_b = qual && hit_b && (ctrl_ff[`LTR_CTRL_QCLK_EN] || !hit_b_d_ff);

   // Disarm requests: synced rising edge of the external reset, or software
   assign ext_rst_pulse = rs_s2_ff && !rs_prev_ff;
   assign sw_rst_pulse = ctrl_ff[`LTR_CTRL_SW_RESET];

   //////////////////////////////////////////////////////////////////////
   // Sequencer
   always @* begin
      nxt_state = state_ff;
      ev_arm = 1'b0;
      ev_trig = 1'b0;
      if (!ctrl_ff[`LTR_CTRL_SEQ]) begin
         nxt_state = ST_IDLE;
         ev_trig = ctrl_ff[`LTR_CTRL_SEL_B] ? rise_b : rise_a;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (rise_a) begin
                  nxt_state = ST_ARMED;
                  ev_arm = 1'b1;
               end
            end
            ST_ARMED: begin
               if (ext_rst_pulse || sw_rst_pulse) begin
                  nxt_state = ST_IDLE;
               end else if (rise_b) begin
                  nxt_state = ST_IDLE;
                  ev_trig = 1'b1;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   // Sticky events; set wins over write-one-to-clear
   always @* begin
      nxt_irq_stat = irq_stat_ff;
      if (wr_en && (paddr == `LTR_OFS_IRQ_STAT)) begin
         nxt_irq_stat = irq_stat_ff & ~pwdata[2:0];
      end
      if (ev_arm) begin
         nxt_irq_stat[`LTR_IRQ_ARM] = 1'b1;
      end
      if (ev_trig) begin
         nxt_irq_stat[`LTR_IRQ_TRIG] = 1'b1;
      end
      if (ext_rst_pulse) begin
         nxt_irq_stat[`LTR_IRQ_EXTRST] = 1'b1;
      end
   end

   // Registered state and outputs
   always @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         hit_a_d_ff <= 1'b0;
         hit_b_d_ff <= 1'b0;
         irq_stat_ff <= 3'h0;
         trigger_out <= 1'b0;
         seq_gate <= 1'b0;
         trigger_monitor_trace <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         hit_a_d_ff <= hit_a;
         hit_b_d_ff <= hit_b;
         irq_stat_ff <= nxt_irq_stat;
         trigger_out <= ev_trig;
         seq_gate <= (nxt_state == ST_ARMED);
         trigger_monitor_trace <= ctrl_ff[`LTR_CTRL_SEQ] ? hit_b :
            (ctrl_ff[`LTR_CTRL_SEL_B] ? hit_b : hit_a);
      end
   end

   // Level interrupt while any unmasked flag is set
   assign irq = |(irq_stat_ff & irq_mask_ff);
endmodule // ltr_recognizer

//--- ltr_consts.vh
// Constants for the logic trigger recognizer: register map, fields, timing
`ifndef LTR_CONSTS_VH
`define LTR_CONSTS_VH
// Register byte offsets
`define LTR_OFS_CTRL 12'h000
`define LTR_OFS_FUNC_A0 12'h004
`define LTR_OFS_FUNC_A1 12'h008
`define LTR_OFS_FUNC_B0 12'h00C
`define LTR_OFS_FUNC_B1 12'h010
`define LTR_OFS_FILTER 12'h014
`define LTR_OFS_STATUS 12'h018
`define LTR_OFS_IRQ_STAT 12'h01C
`define LTR_OFS_IRQ_MASK 12'h020
// Control register fields
`define LTR_CTRL_SEL_B 0
`define LTR_CTRL_SEQ 1
`define LTR_CTRL_QCLK_EN 2
`define LTR_CTRL_QCLK_FALL 3
`define LTR_CTRL_SW_RESET 4
// Product term fields: [3:0] care, [7:4] level, [9:8] edge channel,
// [11:10] edge mode (0 none, 1 rise, 2 fall, 3 either), [12] enable
`define LTR_PT_CARE_LO 0
`define LTR_PT_LVL_LO 4
`define LTR_PT_ECH_LO 8
`define LTR_PT_EMODE_LO 10
`define LTR_PT_EN 12
`define LTR_EDGE_NONE 2'h0
`define LTR_EDGE_RISE 2'h1
`define LTR_EDGE_FALL 2'h2
`define LTR_EDGE_ANY 2'h3
// Interrupt status bits
`define LTR_IRQ_ARM 0
`define LTR_IRQ_TRIG 1
`define LTR_IRQ_EXTRST 2
// Reset values
`define LTR_CTRL_RST 5'h00
`define LTR_PT_RST 13'h0000
`define LTR_FILTER_RST 5'h00
`define LTR_MASK_RST 3'h0
// Filter timing: longest hold 300 ns at a 10 ns clock
`define LTR_FILTER_MAX_NS 300
`define LTR_CLK_PERIOD_NS 10
`define LTR_FILTER_MAX_CYC (`LTR_FILTER_MAX_NS / `LTR_CLK_PERIOD_NS)
`endif

//--- ltr_product.v
// One product term: level literals plus at most one edge literal
`timescale 1ns/1ns
`include "ltr_consts.vh"
module ltr_product (
   // Term configuration
   input wire [12:0] term_cfg,
   // Channel levels now and one cycle earlier
   input wire [3:0] lvl_now,
   input wire [3:0] lvl_prev,
   // Results
   output wire term_true,
   output wire term_has_edge
);
   wire [3:0] care;
   wire [3:0] want;
   wire [1:0] ech;
   wire [1:0] emode;
   wire levels_ok;
   wire edge_ok;
   wire cur;
   wire prv;
   assign care = term_cfg[`LTR_PT_CARE_LO +: 4];
   assign want = term_cfg[`LTR_PT_LVL_LO +: 4];
   assign ech = term_cfg[`LTR_PT_ECH_LO +: 2];
   assign emode = term_cfg[`LTR_PT_EMODE_LO +: 2];
   assign term_has_edge = term_cfg[`LTR_PT_EN] && (emode != `LTR_EDGE_NONE);
   // Edge channel is excluded from level matching so only one edge exists
   assign levels_ok = ((lvl_now ^ want) & care & ~(term_has_edge ? (4'h1 << ech) : 4'h0))
      == 4'h0;
   assign cur = lvl_now[ech];
   assign prv = lvl_prev[ech];
   // Edge detect against the previous sample
   assign edge_ok = (emode == `LTR_EDGE_RISE) ? (cur & ~prv) :
      (emode == `LTR_EDGE_FALL) ? (~cur & prv) :
      (emode == `LTR_EDGE_ANY) ? (cur ^ prv) : 1'b1;
   assign term_true = term_cfg[`LTR_PT_EN] && levels_ok && edge_ok;
endmodule // ltr_product

//--- ltr_function.v
// One trigger function: two product terms ORed, with glitch-qualify filter
`timescale 1ns/1ns
`include "ltr_consts.vh"
module ltr_function (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Configuration
   input wire [12:0] term0_cfg,
   input wire [12:0] term1_cfg,
   input wire [4:0] filter_cyc,
   // Channel samples
   input wire [3:0] lvl_now,
   input wire [3:0] lvl_prev,
   // Recognition, level true while raw function true and, for pure-level functions, filter expired
   output wire func_hit
);
   wire t0;
   wire t1;
   wire e0;
   wire e1;
   wire raw;
   wire has_edge;
   reg [4:0] cnt_ff;
   reg [4:0] nxt_cnt;
   ltr_product u_t0 (
      .term_cfg(term0_cfg),
      .lvl_now(lvl_now),
      .lvl_prev(lvl_prev),
      .term_true(t0),
      .term_has_edge(e0)
   );
   ltr_product u_t1 (
      .term_cfg(term1_cfg),
      .lvl_now(lvl_now),
      .lvl_prev(lvl_prev),
      .term_true(t1),
      .term_has_edge(e1)
   );
   // Sum of two products
   assign raw = t0 | t1;
   assign has_edge = e0 | e1;
   // Count continuous true cycles; false before expiry clears it
   always @* begin
      nxt_cnt = cnt_ff;
      if (!raw) begin
         nxt_cnt = 5'h00;
      end else if (cnt_ff < filter_cyc) begin
         nxt_cnt = cnt_ff + 5'h01;
      end
   end
   always @(posedge clock) begin
      if (sys_rst) begin
         cnt_ff <= 5'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   // Filter only on pure-level functions
   assign func_hit = raw && (has_edge || (cnt_ff >= filter_cyc));
endmodule // ltr_function

//--- ltr_recognizer_assertions.sv
// Port checker for the logic trigger recognizer
`timescale 1ns/1ns
module ltr_checker (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Trigger side
   input wire ext_seq_reset,
   input wire trigger_out,
   input wire seq_gate,
   input wire irq
);
   logic seq_ff;
   // Shadow of the sequential mode bit
   always @(posedge clock) begin
      if (sys_rst)
         seq_ff <= 1'b0;
      else if (psel && penable && pwrite && paddr == 12'h000)
         seq_ff <= pwdata[1];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_apb_no_wait: assert property (pready && !pslverr)
      else $error("apb slave stalled or flagged an error");
   a_reset_quiet: assert property ($fell(sys_rst) |->
      !trigger_out && !seq_gate && !irq && prdata == 32'h0)
      else $error("output active right after reset");
   a_trig_pulse: assert property (trigger_out |=> !trigger_out)
      else $error("trigger longer than one cycle");
   a_trig_drops_gate: assert property (trigger_out |-> !seq_gate)
      else $error("gate still high with trigger");
   a_seq_needs_arm: assert property (seq_ff && trigger_out |-> $past(seq_gate))
      else $error("sequential trigger while idle");
   a_ext_disarm: assert property ($rose(ext_seq_reset) |-> ##[1:4] !seq_gate)
      else $error("external reset did not disarm");
   a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read");
   a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 12'h020
      |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_gate_needs_seq: assert property ($rose(seq_gate) |-> $past(seq_ff))
      else $error("gate rose outside sequential mode");
endmodule // ltr_checker
bind ltr_recognizer ltr_checker chk_i (.clock(clock), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ext_seq_reset(ext_seq_reset),
   .trigger_out(trigger_out), .seq_gate(seq_gate), .irq(irq));

//--- ltr_mainframe.sv
// Mainframe trigger path and delay unit model
`timescale 1ns/1ns
module ltr_mainframe (
   // Clock
   input wire clock,
   // From the recognizer
   input wire trigger_out,
   input wire seq_gate,
   // Delay unit setup
   input wire delay_en,
   input wire [7:0] delay_cyc,
   // To the recognizer
   output logic ext_seq_reset,
   output int trig_cnt
);
   logic [7:0] cnt_ff;
   initial begin
      ext_seq_reset = 1'b0;
      trig_cnt = 0;
      cnt_ff = 8'h00;
   end
   always @(posedge clock) begin
      if (trigger_out)
         trig_cnt <= trig_cnt + 1;
      // Delay by time: starts on gate, resets the recognizer on expiry
      if (!seq_gate || !delay_en)
         cnt_ff <= 8'h00;
      else if (cnt_ff != 8'hFF)
         cnt_ff <= cnt_ff + 8'h01;
      ext_seq_reset <= delay_en && seq_gate && cnt_ff >= delay_cyc;
   end
endmodule // ltr_mainframe

//--- ltr_tb.sv
// Self-checking bench for the logic trigger recognizer
`timescale 1ns/1ns
module testbench;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] chan = 4'h0;
   logic qclk = 1'b0;
   logic delay_en = 1'b0;
   logic [31:0] rd;
   wire [31:0] prdata;
   wire pready, pslverr, ext_rst, trig, gate, trace, irq;
   int trig_cnt;
   int error_cnt = 0;
   int compares = 0;
   always #5 clock = ~clock;
   ltr_recognizer DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_level(chan), .external_qualify_clock(qclk),
      .ext_seq_reset(ext_rst), .trigger_out(trig), .seq_gate(gate),
      .trigger_monitor_trace(trace), .irq(irq));
   ltr_mainframe mainframe (.clock(clock), .trigger_out(trig), .seq_gate(gate),
      .delay_en(delay_en), .delay_cyc(8'h06), .ext_seq_reset(ext_rst), .trig_cnt(trig_cnt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic cnt(input int n, input int e);
      int t0;
      t0 = trig_cnt;
      repeat (n) @(posedge clock);
      chk(32'(trig_cnt - t0), 32'(e));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdchk(12'h000, 32'h0);
      rdchk(12'h014, 32'h0);
      rdchk(12'h018, 32'h0);
      apb(1'b1, 12'h024, 32'hFFFF);
      rdchk(12'h024, 32'h0);
   endtask
   task automatic t_level;
      apb(1'b1, 12'h004, 32'h10AF);
      apb(1'b1, 12'h008, 32'h105F);
      chan <= 4'hA;
      cnt(10, 1);
      chk(32'(trace), 32'h1);
      chan <= 4'h0;
      cnt(6, 0);
      chan <= 4'h5;
      cnt(10, 1);
      chan <= 4'h7;
      cnt(6, 0);
      apb(1'b1, 12'h000, 32'h1);
      chan <= 4'hA;
      cnt(10, 0);
      chk(32'(irq), 32'h0);
      apb(1'b1, 12'h020, 32'h2);
      chk(32'(irq), 32'h1);
      apb(1'b1, 12'h01C, 32'h2);
      chk(32'(irq), 32'h0);
      chan <= 4'h0;
   endtask
   task automatic t_filter;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h014, 32'h5);
      apb(1'b1, 12'h004, 32'h1011);
      apb(1'b1, 12'h008, 32'h0);
      chan <= 4'h1;
      repeat (3) @(posedge clock);
      chan <= 4'h0;
      cnt(12, 0);
      chan <= 4'h1;
      cnt(16, 1);
      chan <= 4'h0;
      apb(1'b1, 12'h014, 32'h28);
      rdchk(12'h014, 32'h1E);
      chan <= 4'h1;
      cnt(25, 0);
      cnt(20, 1);
      chan <= 4'h0;
   endtask
   task automatic t_edge;
      for (int m = 1; m < 4; m++) begin
         apb(1'b1, 12'h00C, 32'h1111 | (m << 10));
         apb(1'b1, 12'h000, 32'h1);
         chan <= 4'h1;
         cnt(8, 0);
         chan <= 4'h3;
         cnt(8, m != 2);
         chan <= 4'h1;
         cnt(8, m != 1);
         chan <= 4'h0;
      end
   endtask
   task automatic t_seq;
      apb(1'b1, 12'h014, 32'h0);
      apb(1'b1, 12'h00C, 32'h1500);
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h01C, 32'h7);
      chan <= 4'h2;
      cnt(8, 0);
      chan <= 4'h1;
      cnt(8, 0);
      chk(32'(gate), 32'h1);
      rdchk(12'h018, 32'h23);
      chan <= 4'h2;
      cnt(8, 1);
      chk(32'(gate), 32'h0);
      rdchk(12'h01C, 32'h3);
      apb(1'b1, 12'h01C, 32'h7);
      chan <= 4'h0;
   endtask
   task automatic t_ext;
      delay_en <= 1'b1;
      chan <= 4'h1;
      repeat (3) @(posedge clock);
      chan <= 4'h0;
      repeat (3) @(posedge clock);
      chk(32'(gate), 32'h1);
      cnt(30, 0);
      chk(32'(gate), 32'h0);
      rdchk(12'h01C, 32'h5);
      delay_en <= 1'b0;
      chan <= 4'h1;
      repeat (8) @(posedge clock);
      chk(32'(gate), 32'h1);
      chan <= 4'h0;
      apb(1'b1, 12'h000, 32'h12);
      @(posedge clock);
      chk(32'(gate), 32'h0);
   endtask
   task automatic t_qclk;
      apb(1'b1, 12'h000, 32'h4);
      chan <= 4'h1;
      cnt(10, 0);
      qclk <= 1'b1;
      cnt(8, 1);
      qclk <= 1'b0;
      cnt(8, 0);
      apb(1'b1, 12'h000, 32'hC);
      qclk <= 1'b1;
      cnt(8, 0);
      qclk <= 1'b0;
      cnt(8, 1);
      chan <= 4'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      t_regs();
      t_level();
      t_filter();
      t_edge();
      t_seq();
      t_ext();
      t_qclk();
      results();
   end
endmodule // testbench
